// ===== logic/phy_autoneg_energy_regs.sv
`timescale 1ns/1ps
`default_nettype none

module phy_autoneg_energy_regs
  import phy_an_pkg::*;
#(
  parameter int          MS_TICK_CYCLES = MS_CYCLES,
  parameter logic [15:0] OUI_HIGH       = 16'h0ABC,  // Arbitrary value
  parameter logic [5:0]  OUI_LOW        = 6'h15,     // Arbitrary value
  parameter logic [5:0]  MODEL          = 6'h0A,     // Arbitrary value
  parameter logic [3:0]  REVISION       = 4'h1       // Arbitrary value
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        softReset,
  input  wire logic [4:0]  regIndex,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [15:0] regWdata,
  output logic [15:0]      regRdata,
  output logic             regReadValid,
  input  wire logic        codeWordValid,
  input  wire logic [15:0] codeWord,
  input  wire logic        partnerAnAble,
  input  wire logic        parallelFault,
  input  wire logic        anComplete,
  output logic             pauseSym,
  output logic             pauseAsym,
  input  wire logic        energySleepEnable,
  input  wire logic        linkPulseIn,
  output logic             txLinkPulse,
  output logic             wakeUp,
  input  wire logic        autoCrossoverEn,
  input  wire logic        forcedSpeed,
  output logic [12:0]      crossoverExtendMs
);

  // Refused at elaboration: a shorter tick leaves no idle cycle
  if (MS_TICK_CYCLES < 2)
  begin : g_tick_check
    $error("MS_TICK_CYCLES must be at least 2");
  end

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [15:0] idLow;
  logic [15:0] adv;
  logic [15:0] partner;
  logic [15:0] timing;
  logic        faultLatch;
  logic        pageRecvLatch;
  logic [31:0] tickCount;
  logic        msTick;
  rx_state_t   rxState;

  wire writeIdLow  = regWrite && (regIndex == IDX_ID_LOW);
  wire writeAdv    = regWrite && (regIndex == IDX_ADV);
  wire writeTiming = regWrite && (regIndex == IDX_TIMING);
  wire readExpand  = regRead && (regIndex == IDX_EXPAND);

  wire [15:0] idHighShown = OUI_HIGH;
  wire [15:0] idLowReset  = {OUI_LOW, MODEL, REVISION};
  wire [15:0] expandShown = {11'h000, faultLatch, partner[LP_NEXT_PAGE],
                             1'b0, pageRecvLatch, partnerAnAble};

  // Unmapped indexes read zero so a scan of the space is harmless
  function automatic logic [15:0] readMux(input logic [4:0] idx, input logic [15:0] exp);
    unique case (idx)
      IDX_ID_HIGH: readMux = idHighShown;
      IDX_ID_LOW:  readMux = idLow;
      IDX_ADV:     readMux = adv;
      IDX_PARTNER: readMux = partner;
      IDX_EXPAND:  readMux = exp;
      IDX_TIMING:  readMux = timing;
      default:     readMux = 16'h0000;
    endcase
  endfunction

  function automatic logic [10:0] txInterval(input logic [1:0] sel);
    unique case (sel)
      2'b00: txInterval = TX_MS_00;
      2'b01: txInterval = TX_MS_01;
      2'b10: txInterval = TX_MS_10;
      2'b11: txInterval = TX_MS_11;
    endcase
  endfunction

  function automatic logic [10:0] rxWindow(input logic [1:0] sel);
    unique case (sel)
      2'b00: rxWindow = RX_MS_00;
      2'b01: rxWindow = RX_MS_01;
      2'b10: rxWindow = RX_MS_10;
      2'b11: rxWindow = RX_MS_11;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Management access, index based
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      regRdata     <= 16'h0000;
      regReadValid <= 1'b0;
    end
    else
    begin
      regReadValid <= regRead;
      if (regRead)
        regRdata <= readMux(regIndex, expandShown);
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      idLow <= {OUI_LOW, MODEL, REVISION};
      adv   <= ADV_RESET;
    end
    else if (softReset)
    begin
      idLow <= idLowReset;
      adv   <= ADV_RESET;
    end
    else
    begin
      if (writeIdLow)
        idLow <= regWdata;
      if (writeAdv)
        adv <= (regWdata & ADV_WMASK) | (adv & ~ADV_WMASK);
    end
  end

  // Timing fields keep their value through soft reset
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      timing <= TIMING_RESET;
    else if (writeTiming)
      timing <= regWdata & TIMING_WMASK;
  end

  // ------------------------------------------------------------
  // Link partner and expansion status
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      partner <= PARTNER_RESET;
    else if (softReset)
      partner <= PARTNER_RESET;
    else if (codeWordValid)
      partner <= codeWord | (16'h0001 << LP_ACK);
  end

  // Set wins over the clear caused by a read in the same cycle
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      faultLatch    <= 1'b0;
      pageRecvLatch <= 1'b0;
    end
    else if (softReset)
    begin
      faultLatch    <= 1'b0;
      pageRecvLatch <= 1'b0;
    end
    else
    begin
      faultLatch    <= parallelFault || (faultLatch && !readExpand);
      pageRecvLatch <= codeWordValid || (pageRecvLatch && !readExpand);
    end
  end

  // ------------------------------------------------------------
  // Pause resolution
  // ------------------------------------------------------------
  wire bothSym  = adv[PAUSE_SYM] && partner[PAUSE_SYM];
  wire bothAsym = adv[PAUSE_ASYM] && partner[PAUSE_ASYM]
                  && (adv[PAUSE_SYM] != partner[PAUSE_SYM]);

  // Symmetric takes priority so only one kind is ever chosen
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pauseSym  <= 1'b0;
      pauseAsym <= 1'b0;
    end
    else
    begin
      pauseSym  <= anComplete && bothSym;
      pauseAsym <= anComplete && !bothSym && bothAsym;
    end
  end

  // ------------------------------------------------------------
  // Millisecond tick
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tickCount <= 32'd0;
      msTick    <= 1'b0;
    end
    else if (tickCount == 32'(MS_TICK_CYCLES - 1))
    begin
      tickCount <= 32'd0;
      msTick    <= 1'b1;
    end
    else
    begin
      tickCount <= tickCount + 32'd1;
      msTick    <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Energy-detect sleep pulses and wake
  // ------------------------------------------------------------
  wire sleepTx = energySleepEnable && timing[TM_TX_EN];
  logic txExpired;
  logic txActive;
  logic rxExpired;
  logic rxActive;

  ms_interval_timer u_tx_timer
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .msTick  (msTick),
    .start   (sleepTx && !txActive),
    .stop    (!sleepTx),
    .limitMs (txInterval(timing[TM_TX_SEL_LSB +: 2])),
    .expired (txExpired),
    .active  (txActive)
  );

  wire singleWake = energySleepEnable && timing[TM_RX_SINGLE] && linkPulseIn;
  wire pairWake   = energySleepEnable && !timing[TM_RX_SINGLE] && linkPulseIn
                    && (rxState == RX_WINDOW);
  wire rxOpen     = energySleepEnable && !timing[TM_RX_SINGLE] && linkPulseIn
                    && (rxState == RX_IDLE);

  ms_interval_timer u_rx_timer
  (
    .sys_clk (sys_clk),
    .rst     (rst),
    .msTick  (msTick),
    .start   (rxOpen),
    .stop    (!energySleepEnable || pairWake),
    .limitMs (rxWindow(timing[TM_RX_SEL_LSB +: 2])),
    .expired (rxExpired),
    .active  (rxActive)
  );

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      txLinkPulse <= 1'b0;
      wakeUp      <= 1'b0;
      rxState     <= RX_IDLE;
    end
    else
    begin
      txLinkPulse <= sleepTx && txExpired;
      wakeUp      <= singleWake || pairWake;
      unique case (rxState)
        RX_IDLE:   if (rxOpen) rxState <= RX_WINDOW;
        RX_WINDOW: if (!energySleepEnable || pairWake || rxExpired) rxState <= RX_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Crossover extension
  // ------------------------------------------------------------
  wire [12:0] xoSleep  = (energySleepEnable && timing[TM_XO_SLEEP]) ? XO_SLEEP_MS : 13'd0;
  wire [12:0] xoManual = (autoCrossoverEn && forcedSpeed && timing[TM_XO_MANUAL])
                         ? XO_MANUAL_MS : 13'd0;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      crossoverExtendMs <= 13'd0;
    else
      crossoverExtendMs <= xoSleep + xoManual;
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_id_high;
    regRead && regIndex == IDX_ID_HIGH |=> regReadValid && regRdata == OUI_HIGH;
  endproperty
  a_id_high: assert property (p_id_high) else $error("identifier high wrong");

  property p_id_low_reset;
    softReset && !writeIdLow |=> idLow == {OUI_LOW, MODEL, REVISION};
  endproperty
  a_id_low_reset: assert property (p_id_low_reset) else $error("identifier low default wrong");

  property p_pause_one;
    !(pauseSym && pauseAsym);
  endproperty
  a_pause_one: assert property (p_pause_one) else $error("both pause kinds resolved");

  property p_adv_soft;
    softReset |=> adv[8:5] == 4'hF && !adv[ADV_RFAULT] && adv[4:0] == 5'h01;
  endproperty
  a_adv_soft: assert property (p_adv_soft) else $error("advertisement reset wrong");

  property p_ack;
    codeWordValid && !softReset |=> partner[LP_ACK] && partner[11:0] == $past(codeWord[11:0]);
  endproperty
  a_ack: assert property (p_ack) else $error("partner word not captured");

  property p_np_zero;
    regRead && regIndex == IDX_EXPAND |=> regRdata[EXP_NP_ABLE] == 1'b0;
  endproperty
  a_np_zero: assert property (p_np_zero) else $error("next page able set");

  property p_fault_latch;
    parallelFault && !softReset |=> faultLatch [*1] ##1 (faultLatch || $past(readExpand));
  endproperty
  a_fault_latch: assert property (p_fault_latch) else $error("fault not latched");

  property p_page_clear;
    readExpand && !codeWordValid && !softReset |=> !pageRecvLatch;
  endproperty
  a_page_clear: assert property (p_page_clear) else $error("page latch not cleared");

  property p_page_set;
    codeWordValid && !softReset |=> pageRecvLatch;
  endproperty
  a_page_set: assert property (p_page_set) else $error("page latch not set");

  property p_tx_gate;
    txLinkPulse |-> $past(energySleepEnable) && $past(timing[TM_TX_EN]);
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("pulse sent outside sleep");

  property p_single_wake;
    energySleepEnable && timing[TM_RX_SINGLE] && linkPulseIn |=> wakeUp;
  endproperty
  a_single_wake: assert property (p_single_wake) else $error("single pulse did not wake");

  property p_timing_kept;
    softReset && !writeTiming |=> timing == $past(timing);
  endproperty
  a_timing_kept: assert property (p_timing_kept) else $error("timing lost on soft reset");

  c_wake_pair: cover property (pairWake ##1 wakeUp);
  c_tx_pulse:  cover property (txLinkPulse);
  c_page_read: cover property (pageRecvLatch ##1 readExpand);

endmodule

`default_nettype wire

// ===== logic/phy_an_pkg.sv
package phy_an_pkg;

  // ------------------------------------------------------------
  // Register indexes
  // ------------------------------------------------------------
  localparam logic [4:0] IDX_ID_HIGH  = 5'h02;
  localparam logic [4:0] IDX_ID_LOW   = 5'h03;
  localparam logic [4:0] IDX_ADV      = 5'h04;
  localparam logic [4:0] IDX_PARTNER  = 5'h05;
  localparam logic [4:0] IDX_EXPAND   = 5'h06;
  localparam logic [4:0] IDX_TIMING   = 5'h10;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int ID_OUI_LSB      = 10;
  localparam int ID_MODEL_LSB    = 4;
  localparam int ADV_RFAULT      = 13;
  localparam int PAUSE_ASYM      = 11;
  localparam int PAUSE_SYM       = 10;
  localparam int LP_NEXT_PAGE    = 15;
  localparam int LP_ACK          = 14;
  localparam int EXP_PD_FAULT    = 4;
  localparam int EXP_LP_NP_ABLE  = 3;
  localparam int EXP_NP_ABLE     = 2;
  localparam int EXP_PAGE_RX     = 1;
  localparam int EXP_LP_AN_ABLE  = 0;
  localparam int TM_TX_EN        = 15;
  localparam int TM_TX_SEL_LSB   = 13;
  localparam int TM_RX_SINGLE    = 12;
  localparam int TM_RX_SEL_LSB   = 10;
  localparam int TM_XO_SLEEP     = 1;
  localparam int TM_XO_MANUAL    = 0;

  // ------------------------------------------------------------
  // Reset values and writable masks
  // ------------------------------------------------------------
  localparam logic [15:0] ADV_RESET     = 16'h01E1;
  localparam logic [15:0] ADV_WMASK     = 16'h2DFF;
  localparam logic [15:0] TIMING_RESET  = 16'h0000;
  localparam logic [15:0] TIMING_WMASK  = 16'hFC03;
  localparam logic [15:0] PARTNER_RESET = 16'h0000;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam logic [10:0] TX_MS_00 = 11'd1000;
  localparam logic [10:0] TX_MS_01 = 11'd768;
  localparam logic [10:0] TX_MS_10 = 11'd512;
  localparam logic [10:0] TX_MS_11 = 11'd256;
  localparam logic [10:0] RX_MS_00 = 11'd64;
  localparam logic [10:0] RX_MS_01 = 11'd256;
  localparam logic [10:0] RX_MS_10 = 11'd512;
  localparam logic [10:0] RX_MS_11 = 11'd1000;
  localparam logic [12:0] XO_SLEEP_MS  = 13'd2976;
  localparam logic [12:0] XO_MANUAL_MS = 13'd1984;

  typedef enum logic {RX_IDLE, RX_WINDOW} rx_state_t;

endpackage

// ===== logic/ms_interval_timer.sv
`timescale 1ns/1ps
`default_nettype none

module ms_interval_timer
  import phy_an_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        msTick,
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic [10:0] limitMs,
  output logic             expired,
  output logic             active
);

  logic [10:0] count;
  wire         lastTick = active && msTick && (count == limitMs - 11'd1);

  assign expired = lastTick && !start;

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      active <= 1'b0;
      count  <= 11'd0;
    end
    else if (stop)
    begin
      active <= 1'b0;
      count  <= 11'd0;
    end
    else if (start)
    begin
      active <= 1'b1;
      count  <= 11'd0;
    end
    else if (lastTick)
    begin
      active <= 1'b0;
      count  <= 11'd0;
    end
    else if (active && msTick)
      count <= count + 11'd1;
  end

endmodule

`default_nettype wire

// ===== verif/link_partner_model.sv
`timescale 1ns/1ps
`default_nettype none

module link_partner_model
(
  input  wire logic        sys_clk,
  input  wire logic        sendWord,
  input  wire logic [15:0] word,
  input  wire logic        sendPulse,
  output logic             codeWordValid,
  output logic [15:0]      codeWord,
  output logic             linkPulseIn
);
  initial
  begin
    codeWordValid = 1'b0;
    codeWord      = 16'h0000;
    linkPulseIn   = 1'b0;
  end

  // Word toggles off its strobe, so stale data never passes as valid
  always @(posedge sys_clk)
  begin
    codeWordValid <= sendWord;
    codeWord      <= sendWord ? word : ~codeWord;
    linkPulseIn   <= sendPulse;
  end
endmodule

`default_nettype wire

// ===== verif/test_phy_autoneg_energy_regs.sv
`timescale 1ns/1ps
`default_nettype none

module test_phy_autoneg_energy_regs import phy_an_pkg::*;;
  localparam logic [15:0] OUI_H = 16'h1234;  // Arbitrary value
  localparam logic [5:0]  OUI_L = 6'h2A;     // Arbitrary value
  localparam logic [5:0]  MOD   = 6'h15;     // Arbitrary value
  localparam logic [3:0]  REV   = 4'h7;      // Arbitrary value

  typedef struct packed {logic [4:0] idx; logic [15:0] exp;} row_t;

  logic        sys_clk, rst, softReset, regWrite, regRead, regReadValid;
  logic        codeWordValid, partnerAnAble, parallelFault, anComplete;
  logic        pauseSym, pauseAsym, energySleepEnable, linkPulseIn;
  logic        txLinkPulse, wakeUp, autoCrossoverEn, forcedSpeed, sendWord, sendPulse;
  logic [4:0]  regIndex;
  logic [15:0] regWdata, regRdata, codeWord, word;
  logic [12:0] crossoverExtendMs;
  int          num_errors, checks, cycles, wakes, txs, w0;
  int          txMs [4] = '{1000, 768, 512, 256};
  int          rxMs [4] = '{64, 256, 512, 1000};
  row_t        rows [7] = '{'{IDX_ID_HIGH, OUI_H}, '{IDX_ID_LOW, {OUI_L, MOD, REV}},
                            '{IDX_ADV, 16'h01E1}, '{IDX_PARTNER, 16'h0000},
                            '{IDX_EXPAND, 16'h0000}, '{IDX_TIMING, 16'h0000}, '{5'h1F, 16'h0000}};

  phy_autoneg_energy_regs #(.MS_TICK_CYCLES(4), .OUI_HIGH(OUI_H), .OUI_LOW(OUI_L), .MODEL(MOD), .REVISION(REV)) dut
  (
    .sys_clk(sys_clk), .rst(rst), .softReset(softReset), .regIndex(regIndex),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .regReadValid(regReadValid), .codeWordValid(codeWordValid), .codeWord(codeWord),
    .partnerAnAble(partnerAnAble), .parallelFault(parallelFault), .anComplete(anComplete),
    .pauseSym(pauseSym), .pauseAsym(pauseAsym), .energySleepEnable(energySleepEnable),
    .linkPulseIn(linkPulseIn), .txLinkPulse(txLinkPulse), .wakeUp(wakeUp),
    .autoCrossoverEn(autoCrossoverEn), .forcedSpeed(forcedSpeed),
    .crossoverExtendMs(crossoverExtendMs)
  );

  link_partner_model partner
  (
    .sys_clk(sys_clk), .sendWord(sendWord), .word(word), .sendPulse(sendPulse),
    .codeWordValid(codeWordValid), .codeWord(codeWord), .linkPulseIn(linkPulseIn)
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("Checks %0d, errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic rdc(input logic [4:0] i, input logic [15:0] exp);
    @(posedge sys_clk);
    regIndex <= i;
    regRead  <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1;
    chk({15'h0000, regReadValid}, 16'h0001);
    chk(regRdata, exp);
    // Leave on an edge so the caller drives its next inputs there
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    @(posedge sys_clk);
    regIndex <= i;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask

  task automatic srst();
    @(posedge sys_clk);
    softReset <= 1'b1;
    @(posedge sys_clk);
    softReset <= 1'b0;
  endtask

  task automatic send(input logic [15:0] w);
    @(posedge sys_clk);
    word     <= w;
    sendWord <= 1'b1;
    @(posedge sys_clk);
    sendWord <= 1'b0;
    tick(3);
  endtask

  task automatic pulse();
    @(posedge sys_clk);
    sendPulse <= 1'b1;
    @(posedge sys_clk);
    sendPulse <= 1'b0;
    tick(4);
  endtask

  // ------------------------------------------------------------
  // Clock, monitors, timeout
  // ------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Ceiling sits about twice above the expected run length
  always @(posedge sys_clk)
  begin
    cycles++;
    if (wakeUp === 1'b1)
      wakes++;
    if (txLinkPulse === 1'b1)
      txs++;
    if (cycles == 60000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {softReset, regWrite, regRead, sendWord, sendPulse, partnerAnAble} = 6'h00;
    {parallelFault, anComplete, energySleepEnable, autoCrossoverEn, forcedSpeed} = 5'h00;
    regIndex = 5'h00;
    regWdata = 16'h0000;
    word = 16'h0000;
    rst = 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    srst();
    foreach (rows[k])
      rdc(rows[k].idx, rows[k].exp);
    // Writes to read-only places are dropped
    wr(IDX_ID_HIGH, 16'hFFFF);
    rdc(IDX_ID_HIGH, OUI_H);
    wr(IDX_ADV, 16'hFFFF);
    rdc(IDX_ADV, 16'h2DFF);
    wr(IDX_PARTNER, 16'hFFFF);
    rdc(IDX_PARTNER, 16'h0000);
    wr(IDX_TIMING, 16'hFFFF);
    rdc(IDX_TIMING, 16'hFC03);
    // Code word, latched status
    partnerAnAble <= 1'b1;
    send(16'h8DE1);
    rdc(IDX_PARTNER, 16'hCDE1);
    rdc(IDX_EXPAND, 16'h000B);
    rdc(IDX_EXPAND, 16'h0009);
    @(posedge sys_clk);
    parallelFault <= 1'b1;
    @(posedge sys_clk);
    parallelFault <= 1'b0;
    tick(20);
    rdc(IDX_EXPAND, 16'h0019);
    rdc(IDX_EXPAND, 16'h0009);
    // A fault that persists survives the read
    parallelFault <= 1'b1;
    rdc(IDX_EXPAND, 16'h0019);
    rdc(IDX_EXPAND, 16'h0019);
    parallelFault <= 1'b0;
    // Soft reset keeps the timing fields only
    srst();
    rdc(IDX_TIMING, 16'hFC03);
    rdc(IDX_ADV, 16'h01E1);
    rdc(IDX_PARTNER, 16'h0000);
    rdc(IDX_EXPAND, 16'h0001);
    // Pause resolution, local side advertises both kinds
    anComplete <= 1'b1;
    wr(IDX_ADV, 16'h0DE1);
    send(16'h0DE1);
    chk({14'h0000, pauseSym, pauseAsym}, 16'h0002);
    send(16'h0801);
    chk({14'h0000, pauseSym, pauseAsym}, 16'h0001);
    // Wake from sleep; autoneg state is set before sleep
    wr(IDX_TIMING, 16'h1000);
    energySleepEnable <= 1'b1;
    w0 = wakes;
    pulse();
    chk(16'(wakes - w0), 16'h0001);
    wr(IDX_TIMING, 16'h0000);
    w0 = wakes;
    pulse();
    chk(16'(wakes - w0), 16'h0000);
    tick(10);
    pulse();
    chk(16'(wakes - w0), 16'h0001);
    w0 = wakes;
    pulse();
    tick(300);
    pulse();
    tick(300);
    chk(16'(wakes - w0), 16'h0000);
    // Every window length, second pulse just inside it
    for (int c = 0; c < 4; c++)
    begin
      wr(IDX_TIMING, {4'h0, 2'(c), 10'h000});
      w0 = wakes;
      pulse();
      tick(rxMs[c] * 4 - 20);
      pulse();
      chk(16'(wakes - w0), 16'h0001);
    end
    w0 = wakes;
    energySleepEnable <= 1'b0;
    wr(IDX_TIMING, 16'h1000);
    pulse();
    chk(16'(wakes - w0), 16'h0000);
    // Periodic pulses, two per double interval
    for (int c = 0; c < 4; c++)
    begin
      wr(IDX_TIMING, {1'b1, 2'(c), 13'h0000});
      energySleepEnable <= 1'b1;
      w0 = txs;
      tick(txMs[c] * 8 + 40);
      energySleepEnable <= 1'b0;
      chk(16'(txs - w0), 16'h0002);
    end
    wr(IDX_TIMING, 16'h6000);
    energySleepEnable <= 1'b1;
    w0 = txs;
    tick(1200);
    chk(16'(txs - w0), 16'h0000);
    // Crossover extensions
    wr(IDX_TIMING, 16'h0003);
    autoCrossoverEn <= 1'b1;
    tick(3);
    chk({3'h0, crossoverExtendMs}, 16'h0BA0);
    forcedSpeed <= 1'b1;
    tick(3);
    chk({3'h0, crossoverExtendMs}, 16'h1360);
    energySleepEnable <= 1'b0;
    tick(3);
    chk({3'h0, crossoverExtendMs}, 16'h07C0);
    autoCrossoverEn <= 1'b0;
    tick(3);
    chk({3'h0, crossoverExtendMs}, 16'h0000);
    // Hardware reset mid-run clears the kept timing fields too
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    rdc(IDX_ID_LOW, {OUI_L, MOD, REV});
    rdc(IDX_TIMING, 16'h0000);
    rdc(IDX_ADV, 16'h01E1);
    wrap_up();
  end
endmodule

`default_nettype wire
